//--- src/tt8_pkg.sv
/*
 * constants for the eight bit transmit timer: bank, offsets, fields,
 * reset values and write masks.
 * assumes the cpu side reaches the expanded register space by a bank
 * number taken from the register pointer.
 */
package tt8_pkg;

    // ------------------------------------------------------------------
    // bank and offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] TT8_TIMER_BANK   = 4'hD; // bank of the timer
    localparam logic [3:0] TT8_OFS_CTRL     = 4'h0; // timer_control
    localparam logic [3:0] TT8_OFS_AUX      = 4'h1; // auxiliary_control
    localparam logic [3:0] TT8_OFS_LOW      = 4'h4; // low_hold_value
    localparam logic [3:0] TT8_OFS_HIGH     = 4'h5; // high_hold_value

    // ------------------------------------------------------------------
    // timer_control and auxiliary_control fields
    // ------------------------------------------------------------------
    localparam int TT8_CTRL_ENABLE  = 7;   // count_enable_bit
    localparam int TT8_CTRL_SINGLE  = 6;   // 1 single pass, 0 modulo-n
    localparam int TT8_CTRL_TIMEOUT = 5;   // timeout flag
    localparam int TT8_CTRL_PRE_HI  = 4;   // prescale_select msb
    localparam int TT8_CTRL_PRE_LO  = 3;   // prescale_select lsb
    localparam int TT8_CTRL_CAPIE   = 2;   // data capture interrupt enable
    localparam int TT8_CTRL_TOIE    = 1;   // timeout interrupt enable
    localparam int TT8_AUX_INITLVL  = 1;   // initial output level

    localparam logic [7:0] TT8_CTRL_WMASK  = 8'hDE; // stored ctrl bits
    localparam logic [7:0] TT8_AUX_WMASK   = 8'h02; // stored aux bits
    localparam logic [7:0] TT8_CTRL_RESET  = 8'h00;
    localparam logic [7:0] TT8_AUX_RESET   = 8'h00;
    localparam logic [7:0] TT8_HOLD_RESET  = 8'h00;
    localparam logic [7:0] TT8_RP_RESET    = 8'h00;
    localparam logic [7:0] TT8_READ_NONE   = 8'h00; // unmapped read

    // ------------------------------------------------------------------
    // counter constants
    // ------------------------------------------------------------------
    localparam logic [7:0] TT8_CNT_ONE     = 8'h01; // last count step
    localparam logic [7:0] TT8_CNT_ZERO    = 8'h00;
    localparam logic [2:0] TT8_DIV_ZERO    = 3'h0;

    // counter sequencing
    typedef enum logic [1:0] {
        TT8_ST_IDLE,
        TT8_ST_COUNT,
        TT8_ST_RELOAD,
        TT8_ST_DONE
    } tt8_state_t;

endpackage : tt8_pkg

//--- src/tt8_pre_if.sv
/*
 * carrier between the timer core and its prescaler.
 * assumes both ends sit on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
interface tt8_pre_if;
    logic       run;  // prescaler running
    logic [1:0] sel;  // prescale_select
    logic       tick; // one cycle count enable
    modport ctl (output run, output sel, input tick);
    modport div (input run, input sel, output tick);
endinterface : tt8_pre_if
`default_nettype wire

//--- src/tt8_prescale.sv
/*
 * prescaler: turns the system clock into a count enable of 1/1, 1/2,
 * 1/4 or 1/8 of its rate.
 * assumes run and sel come from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none
module tt8_prescale
    import tt8_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    tt8_pre_if.div    pre
);

    // ------------------------------------------------------------------
    // divider
    // ------------------------------------------------------------------
    logic [2:0] div_reg;  // free count while running
    logic [2:0] mask_w;   // low bits that must all be set

    // mask per selection
    always_comb begin
        case (pre.sel)
            2'h0:    mask_w = 3'h0;
            2'h1:    mask_w = 3'h1;
            2'h2:    mask_w = 3'h3;
            default: mask_w = 3'h7;
        endcase
    end

    // counter restarts when stopped so the first tick has full spacing
    always_ff @(posedge clk_i) begin
        if (rst_i || !pre.run) begin
            div_reg <= TT8_DIV_ZERO;
        end else begin
            div_reg <= div_reg + 3'h1;
        end
    end

    assign pre.tick = pre.run && ((div_reg & mask_w) == mask_w);

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    full_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (pre.run && pre.sel == 2'h0) |-> pre.tick)
        else $error("full rate prescale missed a tick");
    eighth_rate_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (pre.tick && pre.sel == 2'h3) |=> !pre.tick [*7])
        else $error("eighth rate ticks too close");

endmodule : tt8_prescale
`default_nettype wire

//--- src/tt8_timer.sv
/*
 * eight bit transmit timer: counter, hold registers, control and the
 * banked register port of the expanded register space.
 * assumes the cpu drives its strobes and data on clk_i, one access
 * per strobe, and keeps the rules it is bound to.
 */
`timescale 1ns/100ps
`default_nettype none
module tt8_timer
    import tt8_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       rp_wr_i,    // register_pointer write strobe
    input  wire logic       reg_wr_i,   // expanded space write strobe
    input  wire logic       reg_rd_i,   // expanded space read strobe
    input  wire logic [3:0] reg_addr_i, // offset inside the bank
    input  wire logic [7:0] wdata_i,    // write data
    output logic      [7:0] rdata_o,    // read data, held
    output logic      [3:0] bank_o,     // selected expanded bank
    output logic      [3:0] group_o,    // working register group
    output logic            timer_output_pin_o,
    output logic            timeout_irq_o,     // one cycle request
    output logic            capture_int_en_o   // capture interrupt enable
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [7:0] rp_reg;     // register_pointer
    logic [7:0] ctrl_reg;   // timer_control without the flag
    logic [7:0] aux_reg;    // auxiliary_control
    logic [7:0] low_reg;    // low_hold_value
    logic [7:0] high_reg;   // high_hold_value
    logic       flag_reg;   // timeout flag
    logic [7:0] cnt_reg;    // eight_bit_counter
    logic       out_reg;    // output level
    logic       first_reg;  // modulo-n first pass still pending
    logic       irq_reg;    // timeout request pulse
    logic [7:0] rdata_reg;  // read data
    tt8_state_t state_reg;  // sequencing

    // ------------------------------------------------------------------
    // decode
    // ------------------------------------------------------------------
    logic in_bank_w;  // access hits the timer bank
    logic ctrl_wr_w;  // timer_control write
    logic aux_wr_w;   // auxiliary_control write
    logic low_wr_w;   // low hold write
    logic high_wr_w;  // high hold write
    logic start_w;    // enable bit goes from 0 to 1
    logic term_w;     // counter steps onto zero
    logic single_w;   // single pass mode
    logic set_w;      // timeout flag set event
    logic tick_w;     // prescaled count enable

    tt8_pre_if pre ();

    assign in_bank_w = (rp_reg[3:0] == TT8_TIMER_BANK);
    assign ctrl_wr_w = reg_wr_i && in_bank_w && reg_addr_i == TT8_OFS_CTRL;
    assign aux_wr_w  = reg_wr_i && in_bank_w && reg_addr_i == TT8_OFS_AUX;
    assign low_wr_w  = reg_wr_i && in_bank_w && reg_addr_i == TT8_OFS_LOW;
    assign high_wr_w = reg_wr_i && in_bank_w && reg_addr_i == TT8_OFS_HIGH;
    assign start_w   = ctrl_wr_w && wdata_i[TT8_CTRL_ENABLE]
                       && !ctrl_reg[TT8_CTRL_ENABLE];
    assign single_w  = ctrl_reg[TT8_CTRL_SINGLE];
    assign tick_w    = pre.tick;
    assign term_w    = tick_w && state_reg == TT8_ST_COUNT
                       && cnt_reg == TT8_CNT_ONE;
    // first modulo-n pass raises no flag
    assign set_w     = term_w && (single_w || !first_reg);

    // ------------------------------------------------------------------
    // prescaler
    // ------------------------------------------------------------------
    assign pre.run = ctrl_reg[TT8_CTRL_ENABLE];
    assign pre.sel = ctrl_reg[TT8_CTRL_PRE_HI:TT8_CTRL_PRE_LO];

    tt8_prescale u_pre (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .pre   (pre.div)
    );

    // ------------------------------------------------------------------
    // register pointer
    // ------------------------------------------------------------------
    // both nibbles stored; only the low one gates the timer bank
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rp_reg <= TT8_RP_RESET;
        end else if (rp_wr_i) begin
            rp_reg <= wdata_i;
        end
    end

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    // bit 5 and bit 0 are not stored here
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= TT8_CTRL_RESET;
        end else if (ctrl_wr_w) begin
            ctrl_reg <= wdata_i & TT8_CTRL_WMASK;
        end
    end

    // auxiliary control keeps only the initial level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            aux_reg <= TT8_AUX_RESET;
        end else if (aux_wr_w) begin
            aux_reg <= wdata_i & TT8_AUX_WMASK;
        end
    end

    // hold registers: writable any time, read only at a load
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_reg  <= TT8_HOLD_RESET;
            high_reg <= TT8_HOLD_RESET;
        end else begin
            if (low_wr_w) begin
                low_reg <= wdata_i;
            end
            if (high_wr_w) begin
                high_reg <= wdata_i;
            end
        end
    end

    // timeout flag: a set in the clearing cycle wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_reg <= 1'b0;
        end else if (set_w) begin
            flag_reg <= 1'b1;
        end else if (ctrl_wr_w && wdata_i[TT8_CTRL_TIMEOUT]) begin
            flag_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // counter sequencing
    // ------------------------------------------------------------------
    // a write that sets the enable bit from 0 wins over any tick in that cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= TT8_ST_IDLE;
            cnt_reg   <= TT8_CNT_ZERO;
            first_reg <= 1'b0;
        end else if (start_w) begin
            state_reg <= TT8_ST_COUNT;
            first_reg <= 1'b1;
            // initial level picks the hold register
            cnt_reg   <= aux_reg[TT8_AUX_INITLVL] ? high_reg : low_reg;
        end else if (!ctrl_reg[TT8_CTRL_ENABLE]) begin
            state_reg <= TT8_ST_IDLE;
        end else if (tick_w) begin
            case (state_reg)
                TT8_ST_COUNT: begin
                    if (cnt_reg == TT8_CNT_ONE) begin
                        cnt_reg   <= TT8_CNT_ZERO;
                        first_reg <= 1'b0;
                        // single pass stops, modulo-n reloads
                        state_reg <= single_w ? TT8_ST_DONE
                                              : TT8_ST_RELOAD;
                    end else begin
                        // zero steps on to FF: no terminal count there
                        cnt_reg <= cnt_reg - TT8_CNT_ONE;
                    end
                end
                TT8_ST_RELOAD: begin
                    // the level now on the pin chooses the source
                    cnt_reg   <= out_reg ? high_reg : low_reg;
                    state_reg <= TT8_ST_COUNT;
                end
                TT8_ST_DONE: begin
                    cnt_reg <= TT8_CNT_ZERO;
                end
                default: begin
                    state_reg <= TT8_ST_IDLE;
                end
            endcase
        end
    end

    // output level: set on enable, toggled at each terminal count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_reg <= 1'b0;
        end else if (start_w) begin
            out_reg <= aux_reg[TT8_AUX_INITLVL];
        end else if (term_w) begin
            out_reg <= !out_reg;
        end
    end

    // interrupt request pulse with the flag set event
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= set_w && ctrl_reg[TT8_CTRL_TOIE];
        end
    end

    // ------------------------------------------------------------------
    // read port
    // ------------------------------------------------------------------
    // read data held until the next read strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= TT8_READ_NONE;
        end else if (reg_rd_i) begin
            if (!in_bank_w) begin
                rdata_reg <= TT8_READ_NONE;
            end else if (reg_addr_i == TT8_OFS_CTRL) begin
                rdata_reg <= ctrl_reg | {2'h0, flag_reg, 5'h00};
            end else if (reg_addr_i == TT8_OFS_AUX) begin
                rdata_reg <= aux_reg;
            end else if (reg_addr_i == TT8_OFS_LOW) begin
                rdata_reg <= low_reg;
            end else if (reg_addr_i == TT8_OFS_HIGH) begin
                rdata_reg <= high_reg;
            end else begin
                rdata_reg <= TT8_READ_NONE;
            end
        end
    end

    assign rdata_o            = rdata_reg;
    assign bank_o             = rp_reg[3:0];
    assign group_o            = rp_reg[7:4];
    assign timer_output_pin_o = out_reg;
    assign timeout_irq_o      = irq_reg;
    assign capture_int_en_o   = ctrl_reg[TT8_CTRL_CAPIE];

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    enable_level_a: assert property (start_w |=>
        timer_output_pin_o == $past(aux_reg[TT8_AUX_INITLVL]))
        else $error("output not at initial level after enable");
    enable_load_a: assert property (start_w |=> cnt_reg ==
        ($past(aux_reg[TT8_AUX_INITLVL]) ? $past(high_reg)
                                         : $past(low_reg)))
        else $error("wrong hold value loaded at enable");
    single_halt_a: assert property ((term_w && single_w && !start_w)
        |=> state_reg == TT8_ST_DONE && cnt_reg == TT8_CNT_ZERO
            && flag_reg)
        else $error("single pass did not halt with flag");
    first_quiet_a: assert property ((term_w && !single_w && first_reg)
        |=> !timeout_irq_o)
        else $error("first modulo pass raised a request");
    reload_src_a: assert property ((tick_w && state_reg == TT8_ST_RELOAD
        && ctrl_reg[TT8_CTRL_ENABLE] && !start_w) |=> cnt_reg ==
        ($past(out_reg) ? $past(high_reg) : $past(low_reg)))
        else $error("reload from wrong hold register");
    modulo_irq_a: assert property ((term_w && !single_w && !first_reg
        && ctrl_reg[TT8_CTRL_TOIE] && !start_w)
        |=> timeout_irq_o && flag_reg)
        else $error("modulo timeout missed flag or request");
    term_toggle_a: assert property ((term_w && !start_w)
        |=> timer_output_pin_o != $past(timer_output_pin_o))
        else $error("output did not toggle at terminal count");
    zero_wrap_a: assert property ((tick_w && state_reg == TT8_ST_COUNT
        && cnt_reg == TT8_CNT_ZERO && ctrl_reg[TT8_CTRL_ENABLE]
        && !start_w) |=> cnt_reg == 8'hFF)
        else $error("count zero did not wrap to FF");
    flag_clear_a: assert property ((ctrl_wr_w
        && wdata_i[TT8_CTRL_TIMEOUT] && !set_w) |=> !flag_reg)
        else $error("flag not cleared by write of one");
    stop_idle_a: assert property ((ctrl_wr_w
        && !wdata_i[TT8_CTRL_ENABLE]) |=> ##1 state_reg == TT8_ST_IDLE)
        else $error("counter kept running after disable");
    bank_split_a: assert property (rp_wr_i |=> bank_o ==
        $past(wdata_i[3:0]) && group_o == $past(wdata_i[7:4]))
        else $error("register pointer split wrong");

    single_pass_c: cover property (term_w && single_w);
    modulo_irq_c:  cover property (term_w && !single_w && !first_reg
                                   && ctrl_reg[TT8_CTRL_TOIE]);
    clear_race_c:  cover property (set_w && ctrl_wr_w
                                   && wdata_i[TT8_CTRL_TIMEOUT]);
    wrap_c:        cover property (tick_w && state_reg == TT8_ST_COUNT
                                   && cnt_reg == TT8_CNT_ZERO);

endmodule : tt8_timer
`default_nettype wire

//--- test/tb_eight_bit_transmit_timer.sv
/*
 * self-checking bench for the eight bit transmit timer: register map,
 * single pass, modulo-n at every prescale, hold updates and count wrap.
 * assumes tt8_pkg and the design sources are compiled before this file.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_eight_bit_transmit_timer
    import tt8_pkg::*;
;
    // ------------------------------------------------------------------
    // signals
    // ------------------------------------------------------------------
    logic       clk_i;        // 20 mhz system clock
    logic       rst_i;        // synchronous, active high
    logic       rp_wr_i;      // pointer write strobe
    logic       reg_wr_i;     // banked write strobe
    logic       reg_rd_i;     // banked read strobe
    logic [3:0] reg_addr_i;   // offset in bank
    logic [7:0] wdata_i;      // write data
    logic [7:0] rdata_o;      // read data
    logic [3:0] bank_o;       // selected bank
    logic [3:0] group_o;      // working group
    logic       pin_o;        // timer output level
    logic       irq_o;        // timeout pulse
    logic       cap_o;        // capture interrupt enable
    int         miscompares;  // mismatches seen
    int         checked;      // comparisons made
    int         cycles;       // hang guard
    int         irq_n;        // timeout pulses counted
    int         d;            // prescale divide
    int         base;         // pulse count at scenario start
    logic       toie;         // timeout interrupt enable
    logic       p;            // saved pin level

    tt8_timer i_dut (
        .clk_i              (clk_i),
        .rst_i              (rst_i),
        .rp_wr_i            (rp_wr_i),
        .reg_wr_i           (reg_wr_i),
        .reg_rd_i           (reg_rd_i),
        .reg_addr_i         (reg_addr_i),
        .wdata_i            (wdata_i),
        .rdata_o            (rdata_o),
        .bank_o             (bank_o),
        .group_o            (group_o),
        .timer_output_pin_o (pin_o),
        .timeout_irq_o      (irq_o),
        .capture_int_en_o   (cap_o)
    );

    // ------------------------------------------------------------------
    // clock, pulse counter and hang guard
    // ------------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // pulses are one cycle wide, so sampling each edge catches all
    always @(posedge clk_i) begin
        cycles++;
        if (irq_o === 1'b1) irq_n++;
        if (cycles == 8000) begin
            miscompares++;
            complete_run();
        end
    end

    // ------------------------------------------------------------------
    // compares and access tasks, all entered 1 ns after an edge
    // ------------------------------------------------------------------
    task cmp8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : cmp8

    task cmp_n(input int got, input int exp);
        checked++;
        if (got != exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : cmp_n

    task step;
        @(posedge clk_i);
        #1;
    endtask : step

    task wr_rp(input logic [7:0] v);
        rp_wr_i = 1'b1;
        wdata_i = v;
        step();
        rp_wr_i = 1'b0;
    endtask : wr_rp

    task wr(input logic [3:0] a, input logic [7:0] v);
        reg_wr_i   = 1'b1;
        reg_addr_i = a;
        wdata_i    = v;
        step();
        reg_wr_i   = 1'b0;
    endtask : wr

    task rd(input logic [3:0] a, input logic [7:0] exp);
        reg_rd_i   = 1'b1;
        reg_addr_i = a;
        step();
        reg_rd_i   = 1'b0;
        cmp8(rdata_o, exp);
    endtask : rd

    // edges until the pin changes; bounded so a stuck pin cannot hang
    task measure(input int exp);
        int   n;
        logic old;
        n   = 0;
        old = pin_o;
        while (pin_o === old && n < 600) begin
            step();
            n++;
        end
        cmp_n(n, exp);
    endtask : measure

    task complete_run;
        $display("checked %0d, miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        rp_wr_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 4'h0;
        wdata_i = 8'h00;
        miscompares = 0;
        checked = 0;
        cycles = 0;
        irq_n = 0;
        repeat (8) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        // pointer split and register map after reset
        cmp8({group_o, bank_o}, 8'h00);
        wr_rp(8'h5D);
        cmp8({group_o, bank_o}, 8'h5D);
        rd(TT8_OFS_CTRL, 8'h00);
        rd(TT8_OFS_AUX, 8'h00);
        rd(TT8_OFS_LOW, 8'h00);
        rd(TT8_OFS_HIGH, 8'h00);
        rd(4'h2, TT8_READ_NONE);
        wr(TT8_OFS_LOW, 8'hA5);
        wr(TT8_OFS_HIGH, 8'h3C);
        rd(TT8_OFS_LOW, 8'hA5);
        rd(TT8_OFS_HIGH, 8'h3C);
        wr(TT8_OFS_AUX, 8'hFF);
        rd(TT8_OFS_AUX, 8'h02);
        // flag bit written 1 on a clear flag stays clear, bit 0 reads 0
        wr(TT8_OFS_CTRL, 8'h3D);
        rd(TT8_OFS_CTRL, 8'h1C);
        cmp8({7'h00, cap_o}, 8'h01);
        wr(TT8_OFS_CTRL, 8'h00);
        cmp8({7'h00, cap_o}, 8'h00);
        // writes into another bank must not land here
        wr_rp(8'h5C);
        wr(TT8_OFS_LOW, 8'h11);
        wr_rp(8'h5D);
        rd(TT8_OFS_LOW, 8'hA5);
        // single pass from the low hold, interrupt enabled
        wr(TT8_OFS_LOW, 8'h03);
        wr(TT8_OFS_AUX, 8'h00);
        base = irq_n;
        wr(TT8_OFS_CTRL, 8'hC2);
        cmp8({7'h00, pin_o}, 8'h00);
        measure(3);
        step();
        step();
        cmp_n(irq_n - base, 1);
        rd(TT8_OFS_CTRL, 8'hE2);
        repeat (10) step();
        cmp8({7'h00, pin_o}, 8'h01);
        wr(TT8_OFS_CTRL, 8'hE2);
        rd(TT8_OFS_CTRL, 8'hC2);
        // modulo-n at each prescale; last pass has the interrupt off
        for (int s = 0; s < 4; s++) begin
            d = 1 << s;
            toie = (s != 3);
            wr(TT8_OFS_CTRL, 8'h00);
            wr(TT8_OFS_LOW, 8'h03);
            wr(TT8_OFS_HIGH, 8'h05);
            wr(TT8_OFS_AUX, 8'h02);
            base = irq_n;
            wr(TT8_OFS_CTRL, {2'b10, 1'b0, s[1:0], 1'b0, toie, 1'b0});
            cmp8({7'h00, pin_o}, 8'h01);
            measure(5 * d);
            measure(4 * d);
            measure(6 * d);
            step();
            step();
            cmp_n(irq_n - base, toie ? 2 : 0);
            rd(TT8_OFS_CTRL, {3'b101, s[1:0], 1'b0, toie, 1'b0});
            // stopping freezes the pin; a 0 write leaves the flag alone
            wr(TT8_OFS_CTRL, 8'h00);
            p = pin_o;
            rd(TT8_OFS_CTRL, 8'h20);
            repeat (12) step();
            cmp8({7'h00, pin_o}, {7'h00, p});
            wr(TT8_OFS_CTRL, 8'h20);
            rd(TT8_OFS_CTRL, 8'h00);
        end
        // new low value written while the high count runs
        wr(TT8_OFS_LOW, 8'h04);
        wr(TT8_OFS_HIGH, 8'h06);
        wr(TT8_OFS_AUX, 8'h00);
        wr(TT8_OFS_CTRL, 8'h80);
        measure(4);
        wr(TT8_OFS_LOW, 8'h07);
        measure(6);
        measure(8);
        // count 0 wraps through FF before reaching terminal count
        wr(TT8_OFS_CTRL, 8'h00);
        wr(TT8_OFS_LOW, 8'h00);
        wr(TT8_OFS_CTRL, 8'hC0);
        measure(256);
        complete_run();
    end
endmodule : tb_eight_bit_transmit_timer
`default_nettype wire
